// ==== rtl/sfc_frame_check.v ====
// serial frame check, frame end detection and parameter write filter
// assumes received and sent bytes are synchronous to clk_i; Wishbone slave
`timescale 1ns/1ns
`include "sfc_defines.vh"
module sfc_frame_check #(
	parameter SILENCE_CYC = `SFC_SILENCE_CYC
) (
	input wire clk_i, // clock
	input wire rst_i, // synchronous reset
	input wire wb_cyc_i, // bus cycle
	input wire wb_stb_i, // strobe
	input wire wb_we_i, // write enable
	input wire [7:0] wb_adr_i, // byte address
	input wire [3:0] wb_sel_i, // byte lanes
	input wire [31:0] wb_dat_i, // write data
	output wire [31:0] wb_dat_o, // read data
	output wire wb_ack_o, // acknowledge
	input wire rx_valid_i, // received byte strobe
	input wire [7:0] rx_data_i, // received byte or char
	input wire tx_valid_i, // outgoing message byte strobe
	input wire [7:0] tx_data_i, // outgoing message byte
	input wire tx_end_i, // message done, append check
	output wire tx_chk_valid_o, // check char valid
	output wire [7:0] tx_chk_char_o, // check char
	input wire tx_chk_ready_i, // check char taken
	output wire frame_ok_o, // good frame for us, answer
	output wire param_wr_o, // parameter write pulse
	output wire [7:0] param_grp_o, // parameter group
	output wire [7:0] param_idx_o, // parameter index
	output wire [15:0] param_data_o, // parameter value
	output wire rtu_mode_o, // active protocol, 1 is RTU
	output wire [7:0] baud_o, // active baud code
	output wire [4:0] do_force_o, // forced digital outputs
	input wire [15:0] unlock_nv_i, // stored unlock value at boot
	output wire [15:0] unlock_o // unlock value to store
);
	localparam S_IDLE = 5'b00001;
	localparam S_HI = 5'b00010;
	localparam S_LO = 5'b00100;
	localparam S_LF = 5'b01000;
	localparam S_RTU = 5'b10000;
	localparam [16:0] SIL = SILENCE_CYC;

	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0] b;
		integer k;
		reg [15:0] r;
		begin
			r = {c[15:8], c[7:0] ^ b};
			for (k = 0; k < 8; k = k + 1) begin
				if (r[0])
					r = (r >> 1) ^ `SFC_CRC_POLY;
				else
					r = r >> 1;
			end
			crc_byte = r;
		end
	endfunction

	function [4:0] hex_val;
		input [7:0] ch;
		begin
			if (ch >= 8'h30 && ch <= 8'h39)
				hex_val = {1'b1, ch[3:0]};
			else if (ch >= 8'h41 && ch <= 8'h46)
				hex_val = {1'b1, ch[3:0] + 4'h9};
			else
				hex_val = 5'h00;
		end
	endfunction

	function [7:0] hex_char;
		input [3:0] n;
		begin
			if (n < 4'hA)
				hex_char = {4'h3, n};
			else
				hex_char = {4'h4, n - 4'h9};
		end
	endfunction

	function writable;
		input [7:0] g;
		input [7:0] i;
		input [15:0] ul;
		begin
			case (g)
			8'h00: writable = i <= `SFC_LAST_G0 && i > 8'h01 &&
				!(i >= 8'h08 && i <= 8'h0D) && i != `SFC_LAST_G0;
			8'h01: writable = i <= `SFC_LAST_G1;
			8'h02: writable = i <= `SFC_LAST_G2;
			8'h03: writable = i <= `SFC_LAST_G3;
			8'h04: writable = i <= `SFC_LAST_G4 && i > 8'h04 &&
				i != 8'h08 && i != 8'h09 &&
				!(i == `SFC_IDX_ADJ && ul != `SFC_UNLOCK_ADJ) &&
				!(i >= `SFC_IDX_OFS_LO && i <= `SFC_IDX_OFS_HI &&
				ul != `SFC_UNLOCK_OFS);
			8'h05: writable = i <= `SFC_LAST_G5 && i != 8'h0A &&
				i != 8'h10 && i != 8'h4C;
			8'h06: writable = i <= `SFC_LAST_G6;
			default: writable = 1'b0;
			endcase
		end
	endfunction

	reg [4:0] st_q;
	reg [3:0] nib_q;
	reg [7:0] fb_q [0:5];
	reg [3:0] cnt_q;
	reg [7:0] sum_q, sum_p1_q;
	reg [15:0] crc_q, crc_p1_q, crc_p2_q;
	reg [16:0] sil_q;
	reg ack_q;
	reg [31:0] dat_q;
	reg [7:0] station_q;
	reg st_chk_q, st_ro_q, st_ok_q;
	reg [15:0] check_q;
	reg mode_q, mode_pend_q;
	reg [7:0] baud_q, baud_pend_q;
	reg [4:0] force_q;
	reg [15:0] unlock_q, unlock_boot_q;
	reg boot_done_q;
	reg ok_q, wr_q, resp_pend_q;
	reg [7:0] grp_q, idx_q;
	reg [15:0] pdat_q;
	reg [7:0] tsum_q;
	reg [15:0] tcrc_q;
	reg [2:0] tstep_q;
	reg tbusy_q;
	reg [7:0] tchar_q;

	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire bus_wr = bus_req & wb_we_i;
	wire [4:0] hx = hex_val(rx_data_i);
	wire [7:0] asc_byte = {nib_q, hx[3:0]};
	reg feed;
	reg [7:0] feed_b;
	reg ev;
	reg start;
	always @* begin
		feed = 1'b0;
		feed_b = rx_data_i;
		ev = 1'b0;
		start = 1'b0;
		if (st_q == S_LO && rx_valid_i && hx[4]) begin
			feed = 1'b1;
			feed_b = asc_byte;
		end
		if (st_q == S_LF && rx_valid_i && rx_data_i == `SFC_CH_LF)
			ev = 1'b1;
		if (st_q == S_RTU && !rx_valid_i && sil_q == SIL - 17'h1)
			ev = 1'b1;
		if (st_q == S_RTU && rx_valid_i)
			feed = 1'b1;
		if (st_q == S_IDLE && mode_q && rx_valid_i && sil_q >= SIL)
			start = 1'b1;
	end

	// receive sequencing and check accumulation
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= S_IDLE;
			nib_q <= 4'h0;
			cnt_q <= 4'h0;
			sum_q <= 8'h00;
			sum_p1_q <= 8'h00;
			crc_q <= `SFC_CRC_INIT;
			crc_p1_q <= `SFC_CRC_INIT;
			crc_p2_q <= `SFC_CRC_INIT;
			sil_q <= 17'h0;
		end else begin
			if (rx_valid_i)
				sil_q <= 17'h0;
			else if (sil_q < SIL)
				sil_q <= sil_q + 17'h1;
			if (start || (!mode_q && rx_valid_i &&
				rx_data_i == `SFC_CH_COLON)) begin
				cnt_q <= 4'h0;
				sum_q <= 8'h00;
				crc_q <= `SFC_CRC_INIT;
				st_q <= mode_q ? S_RTU : S_HI;
			end else begin
				case (st_q)
				S_IDLE: st_q <= S_IDLE;
				S_HI: if (rx_valid_i) begin
					if (rx_data_i == `SFC_CH_CR)
						st_q <= S_LF;
					else if (hx[4]) begin
						nib_q <= hx[3:0];
						st_q <= S_LO;
					end else
						st_q <= S_IDLE;
				end
				S_LO: if (rx_valid_i)
					st_q <= hx[4] ? S_HI : S_IDLE;
				S_LF: if (rx_valid_i)
					st_q <= S_IDLE;
				S_RTU: if (ev)
					st_q <= S_IDLE;
				default: st_q <= S_IDLE;
				endcase
			end
			if (feed || start) begin
				if (start)
					fb_q[0] <= feed_b;
				else if (cnt_q < 4'h6)
					fb_q[cnt_q[2:0]] <= feed_b;
				if (start)
					cnt_q <= 4'h1;
				else if (cnt_q != 4'hF)
					cnt_q <= cnt_q + 4'h1;
				sum_p1_q <= start ? 8'h00 : sum_q;
				sum_q <= (start ? 8'h00 : sum_q) + feed_b;
				crc_p2_q <= start ? `SFC_CRC_INIT : crc_p1_q;
				crc_p1_q <= start ? `SFC_CRC_INIT : crc_q;
				crc_q <= crc_byte(start ? `SFC_CRC_INIT : crc_q, feed_b);
			end
		end
	end

	wire addr_ok = fb_q[0] == station_q && station_q != 8'h00 &&
		station_q != 8'hFF;
	wire chk_ok = mode_q ? (crc_q == 16'h0000 && cnt_q >= 4'h4) :
		(sum_q == 8'h00 && cnt_q >= 4'h3);
	wire is_wr = fb_q[1] == `SFC_CMD_WRITE &&
		cnt_q == (mode_q ? 4'h8 : 4'h7);
	wire wr_ok = writable(fb_q[2], fb_q[3], unlock_boot_q);
	wire [15:0] wdat = {fb_q[4], fb_q[5]};
	wire [7:0] wgrp = fb_q[2];
	wire [7:0] widx = fb_q[3];
	wire ev_good = ev && addr_ok && chk_ok;
	wire do_wr = ev_good && is_wr && wr_ok;
	wire set_chk = ev && addr_ok && !chk_ok;
	wire set_ro = ev_good && is_wr && !wr_ok;
	wire tx_last = tbusy_q && tx_chk_ready_i &&
		tstep_q == (mode_q ? 3'h1 : 3'h3);
	wire quiet = st_q == S_IDLE && !tbusy_q && !resp_pend_q && !ev;
	wire hit_wr = do_wr && wgrp == `SFC_GRP_COMM;
	wire [7:0] lrc_rx = 8'h00 - sum_p1_q;
	wire [7:0] tneg = 8'h00 - tsum_q;

	// parameter side effects and mode switching
	always @(posedge clk_i) begin
		if (rst_i) begin
			ok_q <= 1'b0;
			wr_q <= 1'b0;
			grp_q <= 8'h00;
			idx_q <= 8'h00;
			pdat_q <= 16'h0000;
			check_q <= 16'h0000;
			resp_pend_q <= 1'b0;
			mode_q <= 1'b0;
			mode_pend_q <= 1'b0;
			baud_q <= `SFC_BAUD_RST;
			baud_pend_q <= `SFC_BAUD_RST;
			force_q <= 5'h00;
			unlock_q <= 16'h0000;
			unlock_boot_q <= 16'h0000;
			boot_done_q <= 1'b0;
		end else begin
			if (!boot_done_q) begin
				unlock_boot_q <= unlock_nv_i;
				boot_done_q <= 1'b1;
			end
			ok_q <= ev_good;
			wr_q <= do_wr;
			if (do_wr) begin
				grp_q <= wgrp;
				idx_q <= widx;
				pdat_q <= wdat;
			end
			if (ev_good)
				check_q <= mode_q ? crc_p2_q : {8'h00, lrc_rx};
			if (ev_good)
				resp_pend_q <= 1'b1;
			else if (tx_last)
				resp_pend_q <= 1'b0;
			if (hit_wr && widx == `SFC_IDX_BAUD)
				baud_pend_q <= wdat[7:0];
			if (hit_wr && widx == `SFC_IDX_PROTO)
				mode_pend_q <= wdat[0];
			else if (bus_wr && wb_adr_i == `SFC_OFF_CTRL && wb_sel_i[1])
				mode_pend_q <= wb_dat_i[`SFC_CTRL_PROTO];
			if (quiet) begin
				baud_q <= baud_pend_q;
				mode_q <= mode_pend_q;
			end
			if (do_wr && wgrp == `SFC_GRP_DIAG && widx == `SFC_IDX_FORCE &&
				wdat[15:5] == 11'h000 &&
				(wdat[4:0] & (wdat[4:0] - 5'h01)) == 5'h00)
				force_q <= wdat[4:0];
			if (do_wr && wgrp == `SFC_GRP_EXT && widx == `SFC_IDX_UNLOCK)
				unlock_q <= wdat;
		end
	end

	// check emission for outgoing messages
	always @(posedge clk_i) begin
		if (rst_i) begin
			tsum_q <= 8'h00;
			tcrc_q <= `SFC_CRC_INIT;
			tstep_q <= 3'h0;
			tbusy_q <= 1'b0;
			tchar_q <= 8'h00;
		end else if (!tbusy_q) begin
			if (tx_valid_i) begin
				tsum_q <= tsum_q + tx_data_i;
				tcrc_q <= crc_byte(tcrc_q, tx_data_i);
			end
			if (tx_end_i) begin
				tbusy_q <= 1'b1;
				tstep_q <= 3'h0;
				tsum_q <= tneg;
				tchar_q <= mode_q ? tcrc_q[7:0] :
					hex_char(tneg[7:4]);
			end
		end else if (tx_chk_ready_i) begin
			tstep_q <= tstep_q + 3'h1;
			if (tx_last) begin
				tbusy_q <= 1'b0;
				tsum_q <= 8'h00;
				tcrc_q <= `SFC_CRC_INIT;
			end
			case (tstep_q)
			3'h0: tchar_q <= mode_q ? tcrc_q[15:8] :
				hex_char(tsum_q[3:0]);
			3'h1: tchar_q <= `SFC_CH_CR;
			3'h2: tchar_q <= `SFC_CH_LF;
			default: tchar_q <= 8'h00;
			endcase
		end
	end

	// register port
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			station_q <= `SFC_STATION_RST;
			st_chk_q <= 1'b0;
			st_ro_q <= 1'b0;
			st_ok_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
			if (bus_wr && wb_adr_i == `SFC_OFF_CTRL && wb_sel_i[0])
				station_q <= wb_dat_i[7:0];
			if (set_chk)
				st_chk_q <= 1'b1;
			else if (bus_wr && wb_adr_i == `SFC_OFF_STATUS && wb_sel_i[0] &&
				wb_dat_i[`SFC_ST_CHK])
				st_chk_q <= 1'b0;
			if (set_ro)
				st_ro_q <= 1'b1;
			else if (bus_wr && wb_adr_i == `SFC_OFF_STATUS && wb_sel_i[0] &&
				wb_dat_i[`SFC_ST_RO])
				st_ro_q <= 1'b0;
			if (ev_good)
				st_ok_q <= 1'b1;
			else if (bus_wr && wb_adr_i == `SFC_OFF_STATUS && wb_sel_i[0] &&
				wb_dat_i[`SFC_ST_OK])
				st_ok_q <= 1'b0;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
				`SFC_OFF_CTRL: dat_q <= {23'h0, mode_pend_q, station_q};
				`SFC_OFF_STATUS: dat_q <= {28'h0, mode_q, st_ok_q,
					st_ro_q, st_chk_q};
				`SFC_OFF_CHECK: dat_q <= {16'h0, check_q};
				`SFC_OFF_PARAM: dat_q <= {baud_pend_q, baud_q,
					unlock_boot_q[7:0], 3'h0, force_q};
				default: dat_q <= 32'h0000_0000;
				endcase
			end else
				dat_q <= 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign tx_chk_valid_o = tbusy_q;
	assign tx_chk_char_o = tchar_q;
	assign frame_ok_o = ok_q;
	assign param_wr_o = wr_q;
	assign param_grp_o = grp_q;
	assign param_idx_o = idx_q;
	assign param_data_o = pdat_q;
	assign rtu_mode_o = mode_q;
	assign baud_o = baud_q;
	assign do_force_o = force_q;
	assign unlock_o = unlock_q;
endmodule // sfc_frame_check

// ==== rtl/sfc_defines.vh ====
// constants for the serial frame checker and parameter access block
// assumes a 10 MHz clock and a classic Wishbone register port
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH
// register byte offsets
`define SFC_OFF_CTRL 8'h00
`define SFC_OFF_STATUS 8'h04
`define SFC_OFF_CHECK 8'h08
`define SFC_OFF_PARAM 8'h0C
// reset values
`define SFC_STATION_RST 8'h01
`define SFC_BAUD_RST 8'h00
// status bit positions
`define SFC_ST_CHK 0
`define SFC_ST_RO 1
`define SFC_ST_OK 2
`define SFC_ST_RTU 3
// ctrl field positions
`define SFC_CTRL_PROTO 8
// framing characters
`define SFC_CH_COLON 8'h3A
`define SFC_CH_CR 8'h0D
`define SFC_CH_LF 8'h0A
// check arithmetic
`define SFC_CRC_INIT 16'hFFFF
`define SFC_CRC_POLY 16'hA001
// silence timing
`define SFC_SILENCE_MS 10
`define SFC_CLK_KHZ 10000
`define SFC_SILENCE_CYC (`SFC_SILENCE_MS * `SFC_CLK_KHZ)
// commands and parameter coordinates
`define SFC_CMD_WRITE 8'h06
`define SFC_GRP_EXT 8'h02
`define SFC_GRP_COMM 8'h03
`define SFC_GRP_DIAG 8'h04
`define SFC_IDX_UNLOCK 8'h08
`define SFC_IDX_BAUD 8'h01
`define SFC_IDX_PROTO 8'h02
`define SFC_IDX_FORCE 8'h06
`define SFC_IDX_ADJ 8'h0A
`define SFC_IDX_OFS_LO 8'h0B
`define SFC_IDX_OFS_HI 8'h15
`define SFC_UNLOCK_ADJ 16'h0014
`define SFC_UNLOCK_OFS 16'h0016
// last index per group
`define SFC_LAST_G0 8'h2E
`define SFC_LAST_G1 8'h4C
`define SFC_LAST_G2 8'h43
`define SFC_LAST_G3 8'h0B
`define SFC_LAST_G4 8'h17
`define SFC_LAST_G5 8'h4C
`define SFC_LAST_G6 8'h11
`endif

// ==== verif/sfc_host_model.sv ====
// host side of the serial link: sends chars, takes check chars slowly
// assumes the bench calls put or put2 and reads the got queue
`timescale 1ns/1ns
module sfc_host_model (
	input wire clk_i, // clock
	output logic rx_valid_o, // char strobe
	output logic [7:0] rx_data_o, // char
	input wire tx_chk_valid_i, // check char offered
	input wire [7:0] tx_chk_char_i, // check char
	output logic tx_chk_ready_o // check char taken
);
	logic [7:0] got[$];
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_chk_ready_o = 1'b0;
	end
	// ready only every other offered cycle
	always @(posedge clk_i) begin
		tx_chk_ready_o <= tx_chk_valid_i && !tx_chk_ready_o;
		if (tx_chk_valid_i && tx_chk_ready_o)
			got.push_back(tx_chk_char_i);
	end
	task put(input logic [7:0] b);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_data_o <= b;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~b;
	endtask
	function automatic logic [7:0] asc(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction
	task put2(input logic [7:0] b);
		put(asc(b[7:4]));
		put(asc(b[3:0]));
	endtask
endmodule // sfc_host_model

// ==== verif/sfc_frame_check_monitor.sv ====
// checker on the ports of the frame check block
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ns
module sfc_frame_check_monitor (
	input wire clk_i, // clock
	input wire rst_i, // reset
	input wire wb_cyc_i, // cycle
	input wire wb_stb_i, // strobe
	input wire wb_ack_o, // ack
	input wire [31:0] wb_dat_o, // read data
	input wire tx_end_i, // message done
	input wire tx_chk_ready_i, // char taken
	input wire tx_chk_valid_o, // char offered
	input wire [7:0] tx_chk_char_o, // char
	input wire frame_ok_o, // good frame
	input wire param_wr_o, // write pulse
	input wire [7:0] param_grp_o, // group
	input wire [7:0] param_idx_o, // index
	input wire [15:0] param_data_o, // value
	input wire [4:0] do_force_o // forced outputs
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_offer;
		tx_chk_valid_o && !tx_chk_ready_i;
	endsequence
	property p_ack_due;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_due: assert property (p_ack_due) else $error("ack missing");
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
	property p_ok_pulse;
		frame_ok_o |=> !frame_ok_o;
	endproperty
	a_ok_pulse: assert property (p_ok_pulse) else $error("ok not a pulse");
	property p_wr_ok;
		param_wr_o |-> frame_ok_o;
	endproperty
	a_wr_ok: assert property (p_wr_ok) else $error("write without frame");
	property p_wr_hold;
		!param_wr_o |-> $stable({param_grp_o, param_idx_o, param_data_o});
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("param moved");
	property p_force;
		$onehot0(do_force_o);
	endproperty
	a_force: assert property (p_force) else $error("force not one hot");
	property p_chk_hold;
		s_offer |=> tx_chk_valid_o && $stable(tx_chk_char_o);
	endproperty
	a_chk_hold: assert property (p_chk_hold) else $error("char dropped");
	property p_chk_start;
		tx_end_i && !tx_chk_valid_o |=> tx_chk_valid_o;
	endproperty
	a_chk_start: assert property (p_chk_start) else $error("no check");
endmodule // sfc_frame_check_monitor
bind sfc_frame_check sfc_frame_check_monitor u_sfc_frame_check_monitor (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .tx_end_i,
	.tx_chk_ready_i, .tx_chk_valid_o, .tx_chk_char_o, .frame_ok_o,
	.param_wr_o, .param_grp_o, .param_idx_o, .param_data_o, .do_force_o);

// ==== verif/test_serial_frame_check_param_access.sv ====
// self-checking bench for the frame check block
// assumes the host model on the link and a Wishbone master here
`timescale 1ns/1ns
`include "sfc_defines.vh"
module test_serial_frame_check_param_access;
	localparam SIL = 20;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, tx_valid_i = 1'b0, tx_end_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00, tx_data_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o, rx_valid_i, tx_chk_valid_o, tx_chk_ready_i;
	logic frame_ok_o, param_wr_o, rtu_mode_o;
	logic [7:0] rx_data_i, tx_chk_char_o, param_grp_o, param_idx_o, baud_o;
	logic [15:0] param_data_o, unlock_o;
	logic [15:0] unlock_nv_i = 16'h0000;
	logic [4:0] do_force_o;
	int mismatches = 0, n_compared = 0, n_ok = 0, n_wr = 0, cyc = 0;
	sfc_frame_check #(.SILENCE_CYC(SIL)) u_sfc_frame_check (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_data_i, .tx_valid_i,
		.tx_data_i, .tx_end_i, .tx_chk_valid_o, .tx_chk_char_o,
		.tx_chk_ready_i, .frame_ok_o, .param_wr_o, .param_grp_o,
		.param_idx_o, .param_data_o, .rtu_mode_o, .baud_o, .do_force_o,
		.unlock_nv_i, .unlock_o);
	sfc_host_model u_sfc_host_model (.clk_i, .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .tx_chk_valid_i(tx_chk_valid_o),
		.tx_chk_char_i(tx_chk_char_o), .tx_chk_ready_o(tx_chk_ready_i));
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (frame_ok_o === 1'b1) n_ok++;
		if (param_wr_o === 1'b1) n_wr++;
		if (cyc == 20000) begin
			mismatches++;
			close_out;
		end
	end
	task close_out;
		$display("compared %0d mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task restart(input logic [15:0] v);
		@(posedge clk_i);
		unlock_nv_i <= v;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task st(input logic [31:0] e);
		wb(1'b0, `SFC_OFF_STATUS, 32'h0);
		cmp("status", e, rd & 32'h7);
		wb(1'b1, `SFC_OFF_STATUS, 32'h7);
	endtask
	task frame(input logic [7:0] a, g, i, input logic [15:0] d,
		input logic [7:0] bad);
		logic [7:0] b[7];
		logic [7:0] s;
		b = '{a, `SFC_CMD_WRITE, g, i, d[15:8], d[7:0], 8'h00};
		s = 8'h00;
		for (int k = 0; k < 6; k++) s = s + b[k];
		b[6] = (8'h00 - s) ^ bad;
		u_sfc_host_model.put(`SFC_CH_COLON);
		for (int k = 0; k < 7; k++) u_sfc_host_model.put2(b[k]);
		u_sfc_host_model.put(`SFC_CH_CR);
		u_sfc_host_model.put(`SFC_CH_LF);
		repeat (4) @(posedge clk_i);
	endtask
	task txm(input logic [7:0] m[$], input logic [7:0] e[$]);
		foreach (m[k]) begin
			@(posedge clk_i);
			tx_valid_i <= 1'b1;
			tx_data_i <= m[k];
		end
		@(posedge clk_i);
		tx_valid_i <= 1'b0;
		tx_end_i <= 1'b1;
		@(posedge clk_i);
		tx_end_i <= 1'b0;
		for (int t = 0; t < 200 && u_sfc_host_model.got.size() < e.size(); t++)
			@(posedge clk_i);
		cmp("chars", e.size(), u_sfc_host_model.got.size());
		foreach (e[k]) cmp("char", e[k], u_sfc_host_model.got[k]);
		u_sfc_host_model.got.delete();
	endtask
	task t_regs;
		wb(1'b0, `SFC_OFF_CTRL, 32'h0);
		cmp("ctrl", {24'h0, `SFC_STATION_RST}, rd);
		st(32'h0);
		wb(1'b1, 8'h10, 32'hFFFFFFFF);
		wb(1'b0, 8'h10, 32'h0);
		cmp("unmapped", 32'h0, rd);
		$display("done regs");
	endtask
	task t_access;
		logic [15:0] at[13] = '{16'h0001, 16'h0002, 16'h0008, 16'h000D,
			16'h000E, 16'h002E, 16'h0404, 16'h0407, 16'h0409, 16'h050A,
			16'h0510, 16'h054C, 16'h040B};
		logic ok[13] = '{0, 1, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0, 0};
		int w0;
		for (int k = 0; k < 13; k++) begin
			w0 = n_wr;
			frame(8'h01, at[k][15:8], at[k][7:0], 16'h1234, 8'h00);
			cmp("write", ok[k], n_wr - w0);
			st(ok[k] ? 32'h4 : 32'h6);
		end
		frame(8'h01, 8'h04, 8'h0A, 16'h0001, 8'h00);
		st(32'h6);
		cmp("grp", 8'h04, param_grp_o);
		cmp("idx", 8'h07, param_idx_o);
		cmp("data", 16'h1234, param_data_o);
		w0 = n_ok;
		frame(8'h05, 8'h00, 8'h02, 16'h0001, 8'h00);
		cmp("other station", 0, n_ok - w0);
		frame(8'h01, 8'h00, 8'h02, 16'h0001, 8'h01);
		cmp("bad check", 0, n_ok - w0);
		st(32'h1);
		$display("done access");
	endtask
	task t_force;
		frame(8'h01, 8'h04, `SFC_IDX_FORCE, 16'h0010, 8'h00);
		cmp("force", 5'h10, do_force_o);
		frame(8'h01, 8'h04, `SFC_IDX_FORCE, 16'h0003, 8'h00);
		cmp("force", 5'h10, do_force_o);
		frame(8'h01, 8'h04, `SFC_IDX_FORCE, 16'h0000, 8'h00);
		cmp("force", 5'h00, do_force_o);
		frame(8'h01, `SFC_GRP_EXT, `SFC_IDX_UNLOCK, 16'h0014, 8'h00);
		cmp("unlock", 16'h0014, unlock_o);
		$display("done force");
	endtask
	task t_ascii_tx;
		txm('{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h0A},
			'{8'h46, 8'h30, `SFC_CH_CR, `SFC_CH_LF});
		frame(8'h01, `SFC_GRP_COMM, `SFC_IDX_BAUD, 16'h0002, 8'h00);
		frame(8'h01, `SFC_GRP_COMM, `SFC_IDX_PROTO, 16'h0001, 8'h00);
		wb(1'b0, `SFC_OFF_CHECK, 32'h0);
		cmp("check", 32'h000000F3, rd);
		cmp("baud", `SFC_BAUD_RST, baud_o);
		cmp("mode", 1'b0, rtu_mode_o);
		txm('{8'h01, 8'h03, 8'h02, 8'h01, 8'h00, 8'h01},
			'{8'h46, 8'h38, `SFC_CH_CR, `SFC_CH_LF});
		repeat (3) @(posedge clk_i);
		cmp("baud", 8'h02, baud_o);
		cmp("mode", 1'b1, rtu_mode_o);
		wb(1'b0, `SFC_OFF_PARAM, 32'h0);
		cmp("param", 32'h02020000, rd);
		$display("done ascii tx");
	endtask
	task t_unlock;
		int w0;
		restart(16'h0014);
		w0 = n_wr;
		frame(8'h01, 8'h04, `SFC_IDX_ADJ, 16'h0001, 8'h00);
		cmp("adj write", 1, n_wr - w0);
		frame(8'h01, 8'h04, `SFC_IDX_OFS_LO, 16'h0001, 8'h00);
		cmp("ofs write", 1, n_wr - w0);
		restart(16'h0016);
		w0 = n_wr;
		frame(8'h01, 8'h04, `SFC_IDX_OFS_HI, 16'h0001, 8'h00);
		cmp("ofs write", 1, n_wr - w0);
		wb(1'b0, `SFC_OFF_PARAM, 32'h0);
		cmp("boot unlock", 32'h00001600, rd);
		$display("done unlock");
	endtask
	task t_rtu;
		int w0;
		logic [7:0] at_rtu[8] = '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00,
			8'h64, 8'h89, 8'h99};
		wb(1'b1, `SFC_OFF_CTRL, 32'h00000101);
		repeat (3) @(posedge clk_i);
		cmp("mode", 1'b1, rtu_mode_o);
		wb(1'b0, `SFC_OFF_STATUS, 32'h0);
		cmp("mode bit", 32'h8, rd & 32'h8);
		txm('{8'h01, 8'h03, 8'h01, 8'h01, 8'h00, 8'h02},
			'{8'h94, 8'h37});
		repeat (SIL + 5) @(posedge clk_i);
		w0 = n_wr;
		foreach (at_rtu[k]) u_sfc_host_model.put(at_rtu[k]);
		repeat (SIL + 5) @(posedge clk_i);
		cmp("rtu write", 1, n_wr - w0);
		cmp("rtu grp", 8'h02, param_grp_o);
		cmp("rtu data", 16'h0064, param_data_o);
		wb(1'b0, `SFC_OFF_CHECK, 32'h0);
		cmp("rtu check", 32'h00009989, rd);
		$display("done rtu");
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_access;
		t_force;
		t_ascii_tx;
		t_rtu;
		t_unlock;
		close_out;
	end
endmodule // test_serial_frame_check_param_access
